// File: hw/cst_exec_regs.svh
// Register offsets, field positions, reset values and opcode patterns of the execution slice
`ifndef CST_EXEC_REGS_SVH
`define CST_EXEC_REGS_SVH

// ----------------------------------------
// APB register byte offsets
// ----------------------------------------
`define CST_OFS_INSTR     8'h00
`define CST_OFS_CTRL      8'h04
`define CST_OFS_WREG      8'h08
`define CST_OFS_BANK      8'h0C
`define CST_OFS_STATUS    8'h10
`define CST_OFS_PC        8'h14
`define CST_OFS_MEM_ADDR  8'h18
`define CST_OFS_MEM_DATA  8'h1C
`define CST_OFS_PRODUCT   8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CST_CTRL_TWO_WORD 0
`define CST_STAT_OVF      0
`define CST_STAT_BUSY     8
`define CST_STAT_SKIP     9
`define CST_STAT_ILLEGAL  10
`define CST_STAT_CYC_LO   12

// ----------------------------------------
// Reset values and data memory layout
// ----------------------------------------
`define CST_RST_BYTE      8'h00
`define CST_RST_PC        21'h00000
`define CST_RST_BANK      4'h0
`define CST_ACC_SPLIT     8'h80
`define CST_ACC_HI_BANK   4'hF
`define CST_ADDR_PROD_LO  12'hFF3
`define CST_ADDR_PROD_HI  12'hFF4

// ----------------------------------------
// Opcode patterns and phase timing
// ----------------------------------------
`define CST_PAT_INC_Z     6'h0F
`define CST_PAT_INC_NZ    6'h12
`define CST_PAT_MUL_LIT   8'h0D
`define CST_PAT_MUL_FILE  7'h01
`define CST_PAT_TOGGLE    4'h7
`define CST_PAT_BR_OVF    8'hE4
`define CST_LAST_PHASE    2'h3

`endif

// File: hw/cst_pkg.sv
// Types shared by the execution slice modules
package cst_pkg;

  // ----------------------------------------
  // Decoded operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    op_none,
    op_increment_skip_zero,
    op_increment_skip_nonzero,
    op_multiply_literal,
    op_multiply_file,
    op_bit_toggle,
    op_branch_on_overflow
  } cst_op_e;

  // ----------------------------------------
  // Execution phases
  // ----------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_q1,
    st_q2,
    st_q3,
    st_q4,
    st_nop
  } cst_state_e;

endpackage

// File: hw/cst_decode.sv
// Instruction word decoder of the execution slice
`include "cst_exec_regs.svh"

module cst_decode
  import cst_pkg::*;
(
  // Instruction word
  input  wire logic [15:0] instr,
  // Decoded fields
  output cst_op_e          op,
  output logic             dest,
  output logic             acc,
  output logic [2:0]       bsel,
  output logic [7:0]       faddr,
  output logic [7:0]       lit
);

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  assign dest  = instr[9];
  assign acc   = instr[8];
  assign bsel  = instr[11:9];
  assign faddr = instr[7:0];
  assign lit   = instr[7:0];

  // ----------------------------------------
  // Opcode match
  // ----------------------------------------
  always_comb begin
    op = op_none;
    if (instr[15:10] == `CST_PAT_INC_Z) begin
      op = op_increment_skip_zero; // RULE_01
    end else if (instr[15:10] == `CST_PAT_INC_NZ) begin
      op = op_increment_skip_nonzero; // RULE_03
    end else if (instr[15:8] == `CST_PAT_MUL_LIT) begin
      op = op_multiply_literal; // RULE_09
    end else if (instr[15:9] == `CST_PAT_MUL_FILE) begin
      op = op_multiply_file; // RULE_10
    end else if (instr[15:12] == `CST_PAT_TOGGLE) begin
      op = op_bit_toggle; // RULE_12
    end else if (instr[15:8] == `CST_PAT_BR_OVF) begin
      op = op_branch_on_overflow; // RULE_13
    end
  end

endmodule

// File: hw/cst_exec_core.sv
// Execution slice for skip, multiply, toggle and branch operations with an APB slave
`include "cst_exec_regs.svh"

// Notes on behaviour
// RULE_01: Decode increment-skip-zero, add one to file
// RULE_02: Skip only when incremented result is zero
// RULE_03: Decode increment-skip-nonzero, add one to file
// RULE_04: Skip only when incremented result is nonzero
// RULE_05: Taken skip discards prefetch, adds one nop
// RULE_06: Skip over two-word instruction costs two nops
// RULE_07: Destination bit picks working or file register
// RULE_08: Bank bit picks access bank or pointer
// RULE_09: Literal multiply fills product pair unsigned
// RULE_10: File multiply fills product, operands unchanged
// RULE_11: Multiplies never touch any status flag; the code keeps ovf but rewrites the skip, illegal and cycle status fields
// RULE_12: Toggle selected bit, read Q2, write Q4
// RULE_13: Overflow branch loads pc plus offset, nop
// RULE_14: Product pair readable as data memory
module cst_exec_core
  import cst_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  // APB answer
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0]  mem [0:4095];
  cst_state_e  state_ff;
  logic [15:0] instr_ff;
  logic [11:0] eaddr_ff;
  logic [7:0]  opnd_ff;
  logic [7:0]  res_ff;
  logic [15:0] prod_ff;
  logic [1:0]  phase_ff;
  logic        nop_left_ff;
  logic [7:0]  wreg_ff;
  logic [3:0]  bank_select_pointer_ff;
  logic        ovf_ff;
  logic        two_word_ff;
  logic [20:0] pc_ff;
  logic [11:0] mem_addr_ff;
  logic [7:0]  product_high_ff;
  logic [7:0]  product_low_ff;
  logic        skip_ff;
  logic        illegal_ff;
  logic [1:0]  cyc_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        nxt_pslverr;
  cst_op_e     op;
  logic        dest;
  logic        acc_bit;
  logic [2:0]  bsel;
  logic [7:0]  faddr;
  logic [7:0]  lit;
  logic        acc_ph;
  logic        wr_ok;
  logic        busy;
  logic        start;
  logic        skip;
  logic        is_inc;
  logic        is_mul;
  logic        br_taken;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Effective file address from bank bit, file field and pointer
  function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f,
                                           input logic [3:0] bank);
    if (a) begin
      eff_addr = {bank, f}; // RULE_08
    end else if (f < `CST_ACC_SPLIT) begin
      eff_addr = {4'h0, f}; // RULE_08
    end else begin
      eff_addr = {`CST_ACC_HI_BANK, f}; // RULE_08
    end
  endfunction

  // File read with the product pair overlaid on data memory
  function automatic logic [7:0] rd_file(input logic [11:0] a, input logic [7:0] hi,
                                         input logic [7:0] lo, input logic [7:0] m);
    if (a == `CST_ADDR_PROD_HI) begin
      rd_file = hi; // RULE_14
    end else if (a == `CST_ADDR_PROD_LO) begin
      rd_file = lo; // RULE_14
    end else begin
      rd_file = m;
    end
  endfunction

  // ----------------------------------------
  // Decoder
  // ----------------------------------------
  cst_decode u_decode (
    .instr (instr_ff),
    .op    (op),
    .dest  (dest),
    .acc   (acc_bit),
    .bsel  (bsel),
    .faddr (faddr),
    .lit   (lit)
  );

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  assign acc_ph = psel & penable;
  assign busy   = (state_ff != st_idle);
  assign wr_ok  = acc_ph & pready_ff & pwrite & ~pslverr_ff;
  assign start  = wr_ok & (paddr == `CST_OFS_INSTR);

  // Read data and error selection for the access phase
  always_comb begin
    nxt_prdata  = 32'h00000000;
    nxt_pslverr = pwrite & busy;
    unique case (paddr)
      `CST_OFS_INSTR:    nxt_prdata = {16'h0000, instr_ff};
      `CST_OFS_CTRL:     nxt_prdata = {31'h00000000, two_word_ff};
      `CST_OFS_WREG:     nxt_prdata = {24'h000000, wreg_ff};
      `CST_OFS_BANK:     nxt_prdata = {28'h0000000, bank_select_pointer_ff};
      `CST_OFS_STATUS:   nxt_prdata = {18'h00000, cyc_ff, 1'b0, illegal_ff, skip_ff, busy,
                                       7'h00, ovf_ff};
      `CST_OFS_PC:       nxt_prdata = {11'h000, pc_ff};
      `CST_OFS_MEM_ADDR: nxt_prdata = {20'h00000, mem_addr_ff};
      `CST_OFS_MEM_DATA: nxt_prdata = {24'h000000, rd_file(mem_addr_ff, product_high_ff,
                                       product_low_ff, mem[mem_addr_ff])};
      `CST_OFS_PRODUCT:  nxt_prdata = {16'h0000, product_high_ff, product_low_ff};
      default:           nxt_pslverr = 1'b1;
    endcase
  end

  // Answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff <= acc_ph & ~pready_ff;
      if (acc_ph & ~pready_ff) begin
        pslverr_ff <= nxt_pslverr;
        prdata_ff  <= nxt_prdata;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ----------------------------------------
  // Outcome decode
  // ----------------------------------------
  assign is_inc   = (op == op_increment_skip_zero) | (op == op_increment_skip_nonzero);
  assign is_mul   = (op == op_multiply_literal) | (op == op_multiply_file);
  assign br_taken = (op == op_branch_on_overflow) & ovf_ff; // RULE_13
  assign skip     = ((op == op_increment_skip_zero) & (res_ff == 8'h00))      // RULE_02
                  | ((op == op_increment_skip_nonzero) & (res_ff != 8'h00)); // RULE_04

  // ----------------------------------------
  // Phase sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= st_idle;
      phase_ff    <= 2'h0;
      nop_left_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        st_idle: if (start) state_ff <= st_q1;
        st_q1:   state_ff <= st_q2;
        st_q2:   state_ff <= st_q3;
        st_q3:   state_ff <= st_q4;
        st_q4: begin
          phase_ff <= 2'h0;
          if (skip) begin
            state_ff    <= st_nop; // RULE_05
            nop_left_ff <= two_word_ff; // RULE_06
          end else if (br_taken) begin
            state_ff    <= st_nop; // RULE_13
            nop_left_ff <= 1'b0;
          end else begin
            state_ff <= st_idle;
          end
        end
        st_nop: begin
          phase_ff <= phase_ff + 2'h1;
          if (phase_ff == `CST_LAST_PHASE) begin
            if (nop_left_ff) begin
              nop_left_ff <= 1'b0;
            end else begin
              state_ff <= st_idle;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Datapath: instruction, address, operand, result
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_ff <= 16'h0000;
      eaddr_ff <= 12'h000;
      opnd_ff  <= `CST_RST_BYTE;
      res_ff   <= `CST_RST_BYTE;
      prod_ff  <= 16'h0000;
    end else begin
      if (start) instr_ff <= pwdata[15:0];
      if (state_ff == st_q1) eaddr_ff <= eff_addr(acc_bit, faddr, bank_select_pointer_ff);
      if (state_ff == st_q2) begin
        opnd_ff <= rd_file(eaddr_ff, product_high_ff, product_low_ff, mem[eaddr_ff]);
      end
      if (state_ff == st_q3) begin
        if (is_inc) res_ff <= opnd_ff + 8'h01; // RULE_01 RULE_03
        if (op == op_bit_toggle) res_ff <= opnd_ff ^ (8'h01 << bsel); // RULE_12
        if (op == op_multiply_literal) prod_ff <= wreg_ff * lit; // RULE_09
        if (op == op_multiply_file) prod_ff <= wreg_ff * opnd_ff; // RULE_10
      end
    end
  end

  // ----------------------------------------
  // Data memory, written by software and in Q4
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (wr_ok & (paddr == `CST_OFS_MEM_DATA)) mem[mem_addr_ff] <= pwdata[7:0];
    if ((state_ff == st_q4) & ((is_inc & dest) | (op == op_bit_toggle))) begin
      mem[eaddr_ff] <= res_ff; // RULE_07 RULE_12
    end
  end

  // ----------------------------------------
  // Product pair
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      product_high_ff <= `CST_RST_BYTE;
      product_low_ff  <= `CST_RST_BYTE;
    end else if ((state_ff == st_q4) & is_mul) begin
      product_high_ff <= prod_ff[15:8]; // RULE_09 RULE_10
      product_low_ff  <= prod_ff[7:0];
    end
  end

  // ----------------------------------------
  // Working register, bank pointer, flags, control
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wreg_ff                <= `CST_RST_BYTE;
      bank_select_pointer_ff <= `CST_RST_BANK;
      ovf_ff                 <= 1'b0;
      two_word_ff            <= 1'b0;
      mem_addr_ff            <= 12'h000;
    end else begin
      if (wr_ok & (paddr == `CST_OFS_WREG)) wreg_ff <= pwdata[7:0];
      if ((state_ff == st_q4) & is_inc & ~dest) wreg_ff <= res_ff; // RULE_07
      if (wr_ok & (paddr == `CST_OFS_BANK)) bank_select_pointer_ff <= pwdata[3:0];
      // Overflow changes only by software, never by a multiply
      if (wr_ok & (paddr == `CST_OFS_STATUS)) ovf_ff <= pwdata[`CST_STAT_OVF]; // RULE_11
      if (wr_ok & (paddr == `CST_OFS_CTRL)) two_word_ff <= pwdata[`CST_CTRL_TWO_WORD];
      if (wr_ok & (paddr == `CST_OFS_MEM_ADDR)) mem_addr_ff <= pwdata[11:0];
    end
  end

  // ----------------------------------------
  // Program counter and outcome status
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff      <= `CST_RST_PC;
      skip_ff    <= 1'b0;
      illegal_ff <= 1'b0;
      cyc_ff     <= 2'h0;
    end else begin
      if (wr_ok & (paddr == `CST_OFS_PC)) pc_ff <= {pwdata[20:1], 1'b0};
      if (state_ff == st_q4) begin
        skip_ff    <= skip;
        illegal_ff <= (op == op_none);
        if (br_taken) begin
          pc_ff  <= pc_ff + 21'h2 + {{12{lit[7]}}, lit, 1'b0}; // RULE_13
          cyc_ff <= 2'h2;
        end else if (skip) begin
          pc_ff  <= two_word_ff ? pc_ff + 21'h6 : pc_ff + 21'h4; // RULE_06
          cyc_ff <= two_word_ff ? 2'h3 : 2'h2; // RULE_05
        end else begin
          pc_ff  <= pc_ff + 21'h2;
          cyc_ff <= 2'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_skip_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    (state_ff == st_q4) && (op == op_increment_skip_zero) && (res_ff == 8'h00)
    |=> (state_ff == st_nop))
    else $error("increment-skip-zero did not skip on zero");

  a_noskip_run: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    (state_ff == st_q4) && (op == op_increment_skip_zero) && (res_ff != 8'h00)
    |=> (state_ff == st_idle) && (cyc_ff == 2'h1))
    else $error("increment-skip-zero skipped on nonzero");

  a_skip_nonzero: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    (state_ff == st_q4) && (op == op_increment_skip_nonzero)
    |=> ((state_ff == st_nop) == ($past(res_ff) != 8'h00)))
    else $error("increment-skip-nonzero skip decision wrong");

  a_one_nop: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    (state_ff == st_q4) && skip && !two_word_ff
    |=> (state_ff == st_nop) [*4] ##1 (state_ff == st_idle))
    else $error("single skip nop cycle length wrong");

  a_two_nops: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
    (state_ff == st_q4) && skip && two_word_ff
    |=> (state_ff == st_nop) [*8] ##1 (state_ff == st_idle) && (cyc_ff == 2'h3))
    else $error("two-word skip length wrong");

  a_inc_to_w: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    (state_ff == st_q4) && is_inc && !dest
    |=> (wreg_ff == $past(opnd_ff) + 8'h01))
    else $error("increment result not placed in working register");

  a_access_bank: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    (state_ff == st_q2) && !acc_bit
    |-> (eaddr_ff[11:8] == 4'h0) || (eaddr_ff[11:8] == `CST_ACC_HI_BANK))
    else $error("access bank address outside access bank");

  a_mul_literal: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    (state_ff == st_q3) && (op == op_multiply_literal)
    |=> ##1 ({product_high_ff, product_low_ff} == $past(wreg_ff, 2) * $past(lit, 2)))
    else $error("literal product wrong");

  a_mul_keep: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
    (state_ff == st_q4) && (op == op_multiply_file)
    |=> (wreg_ff == $past(wreg_ff)) && (mem[eaddr_ff] == $past(mem[eaddr_ff])))
    else $error("file multiply changed an operand");

  a_mul_flags: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    (state_ff == st_q4) && is_mul |=> $stable(ovf_ff))
    else $error("multiply changed a flag");

  a_toggle_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE_12
    (state_ff == st_q2) && (op == op_bit_toggle)
    |=> ##2 (mem[eaddr_ff] == ($past(opnd_ff, 2) ^ (8'h01 << bsel))))
    else $error("toggle did not invert the selected bit");

  a_branch_pc: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
    (state_ff == st_q4) && br_taken
    |=> (pc_ff == $past(pc_ff) + 21'h2 + {{12{instr_ff[7]}}, instr_ff[7:0], 1'b0})
        ##0 (state_ff == st_nop) [*4])
    else $error("overflow branch target or nop wrong");

endmodule

// File: tb/tb_top.sv
// Self-checking testbench of the execution slice, driven over APB
`include "cst_exec_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // Design signals and bench state
  // ----------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdat;
  logic        rerr;
  logic [31:0] seed;
  int          mismatches;
  int          comparisons;
  int          mem [0:4095];
  int          w;
  int          bk;
  int          pc;
  int          ovf;
  int          prod;
  int          two;
  int          skp;
  int          cyc;
  int          k;

  // Registers with a documented reset value of zero
  logic [7:0] k_list [6] = '{`CST_OFS_INSTR, `CST_OFS_WREG, `CST_OFS_BANK,
                             `CST_OFS_STATUS, `CST_OFS_PC, `CST_OFS_PRODUCT};

  cst_exec_core dut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // Clock of 50 ns period
  always #25 pclk = ~pclk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Pseudo-random source with a fixed start
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // File address from bank bit and offset, access bank split at 0x80
  function automatic int fa(input int a, input int f);
    if (a == 0) begin
      return (f < 128) ? f : 'hF00 + f;
    end
    return bk * 256 + f;
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; pready is looked at on the falling edge where it is settled,
  // the transfer completes at the following rising edge and is released after it
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
    end
    rdat    = prdata;
    rerr    = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // ----------------------------------------
  // Run one instruction against the model
  // ----------------------------------------
  task automatic run(input logic [15:0] ins);
    int ad;
    int r;
    int n;
    int npc;
    int ill;
    ad = fa(ins[8], ins[7:0]);
    wr(`CST_OFS_INSTR, {16'h0000, ins});
    // A write while the instruction runs is refused and leaves W alone
    wr(`CST_OFS_WREG, w ^ 1);
    chk("busy write", {31'h0, rerr}, 32'h1);
    skp = 0;
    cyc = 1;
    ill = 0;
    npc = pc + 2;
    if (ins[15:10] == 6'h0F || ins[15:10] == 6'h12) begin
      r = (mem[ad] + 1) % 256;
      if (ins[9]) mem[ad] = r;
      else w = r;
      skp = (ins[15:10] == 6'h0F) ? (r == 0) : (r != 0);
    end else if (ins[15:8] == 8'h0D) begin
      prod = w * ins[7:0];
    end else if (ins[15:9] == 7'h01) begin
      prod = w * mem[ad];
    end else if (ins[15:12] == 4'h7) begin
      mem[ad] = mem[ad] ^ (1 << ins[11:9]);
    end else if (ins[15:8] == 8'hE4 && ovf == 1) begin
      cyc = 2;
      npc = pc + 2 + 2 * $signed(ins[7:0]);
    end else if (ins[15:8] != 8'hE4) begin
      ill = 1;
    end
    if (skp != 0) begin
      cyc = 2 + two;
      npc = pc + 4 + 2 * two;
    end
    pc = npc & 'h1FFFFF;
    n = 0;
    do begin
      rd(`CST_OFS_STATUS);
      n++;
    end while (rdat[8] !== 1'b0 && n < 40);
    chk("status", rdat, (cyc << 12) | (ill << 10) | (skp << 9) | ovf);
    rd(`CST_OFS_WREG);
    chk("wreg", rdat, w);
    rd(`CST_OFS_PC);
    chk("pc", rdat, pc);
    rd(`CST_OFS_PRODUCT);
    chk("product", rdat, prod);
    wr(`CST_OFS_MEM_ADDR, ad);
    rd(`CST_OFS_MEM_DATA);
    chk("file", rdat, mem[ad]);
  endtask

  // Load operands and state, then run; a negative value asks for a random byte
  task automatic setup(input logic [15:0] ins, input int val, input int b, input int t,
                       input int o);
    int ad;
    bk  = b;
    two = t;
    ovf = o;
    w   = xs() & 255;
    pc  = xs() & 'h1FFFFE;
    wr(`CST_OFS_BANK, bk);
    wr(`CST_OFS_CTRL, two);
    wr(`CST_OFS_STATUS, ovf);
    wr(`CST_OFS_WREG, w);
    wr(`CST_OFS_PC, pc);
    ad = fa(ins[8], ins[7:0]);
    mem[ad] = (val < 0) ? (xs() & 255) : val;
    wr(`CST_OFS_MEM_ADDR, ad);
    wr(`CST_OFS_MEM_DATA, mem[ad]);
    run(ins);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    seed        = 32'h2800;
    mismatches  = 0;
    comparisons = 0;
    prod        = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values of the visible state
    foreach (k_list[i]) begin
      rd(k_list[i]);
      chk("reset value", rdat, 32'h0);
    end
    // Unmapped offsets are refused
    rd(8'h24);
    chk("unmapped read", {rdat[30:0], rerr}, 32'h1);
    wr(8'h30, 32'h5A);
    chk("unmapped write", {31'h0, rerr}, 32'h1);
    // Increment and skip, both polarities, both banks, both lengths
    setup(16'h3E10, 8'hFF, 0, 0, 0);
    setup(16'h3D22, 8'h41, 3, 0, 0);
    setup(16'h3E10, 8'hFF, 0, 1, 0);
    setup(16'h4B80, 8'h07, 5, 0, 0);
    setup(16'h4890, 8'hFF, 7, 0, 0);
    setup(16'h4B80, 8'h07, 5, 1, 0);
    // Multiplies with overflow set, which must survive
    for (k = 0; k < 3; k++) begin
      setup({8'h0D, 8'(xs())}, -1, 1, 0, 1);
      setup(16'h0220, -1, 0, 0, 1);
      setup(16'h0340, -1, 2, 0, 1);
    end
    // Product pair seen through data memory
    wr(`CST_OFS_MEM_ADDR, `CST_ADDR_PROD_HI);
    rd(`CST_OFS_MEM_DATA);
    chk("product high", rdat, prod >> 8);
    wr(`CST_OFS_MEM_ADDR, `CST_ADDR_PROD_LO);
    rd(`CST_OFS_MEM_DATA);
    chk("product low", rdat, prod & 255);
    // Toggle every bit position
    for (k = 0; k < 8; k++) begin
      setup(16'h7030 | 16'(k << 9), -1, 4, 0, 0);
    end
    setup(16'h7B45, -1, 6, 0, 0);
    // Branch on overflow, forward, backward and not taken
    setup(16'hE405, -1, 0, 0, 1);
    setup(16'hE4FB, -1, 0, 0, 1);
    setup(16'hE47F, -1, 0, 0, 0);
    // Unrecognised opcode runs as a one-cycle no-op and is flagged
    setup(16'hFFFF, -1, 1, 0, 0);
    finish_test();
  end

  // Watchdog against a hang
  initial begin
    #1_000_000;
    mismatches++;
    finish_test();
  end

endmodule
